// [inc/wwd_pkg.sv]
// Shared constants and types of the windowed watchdog.
`default_nettype none
package wwd_pkg;
  // ===========================================================================
  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_TIME_NS = 1000000;
  localparam int unsigned TICK_CYC = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CCP_OPEN_CYC = 4;
  // ===========================================================================
  // Timeout table
  localparam int unsigned MS_W = 14;
  localparam logic [MS_W-1:0] BASE_MS = 14'h0008;
  localparam logic [3:0] SEL_MAX = 4'hB;
  localparam logic [3:0] SEL_OFF = 4'h0;
  localparam logic [3:0] SEL_ONE = 4'h1;
  // ===========================================================================
  // Control A field layout
  localparam int unsigned CTRL_W = 8;
  localparam int unsigned PERIOD_LSB = 0;
  localparam int unsigned WINDOW_LSB = 4;
  localparam int unsigned SEL_W = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  // ===========================================================================
  // Sequencer states
  typedef enum logic [1:0] {
    WWD_OFF = 2'b00,
    WWD_CLOSED = 2'b01,
    WWD_OPEN = 2'b10
  } wwd_state_t;
endpackage
`default_nettype wire

// [src/wwd_tick.sv]
// Millisecond tick generator of the windowed watchdog.
`timescale 1ns/1ps
`default_nettype none
module wwd_tick #(
  parameter int unsigned TICK_CYCLES = wwd_pkg::TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clear,
  output logic tick
);
  localparam int unsigned CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
  localparam logic [CW-1:0] ZERO = '0;
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] cnt_reg;
  logic tick_reg;

  // ===========================================================================
  // Prescaler
  // Clearing with the counter keeps the first millisecond of a period whole.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= ZERO;
      tick_reg <= 1'b0;
    end else if (clear) begin
      cnt_reg <= ZERO;
      tick_reg <= 1'b0;
    end else if (cnt_reg == LAST) begin
      cnt_reg <= ZERO;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + ONE;
      tick_reg <= 1'b0;
    end
  end

  assign tick = tick_reg;
endmodule
`default_nettype wire

// [src/wwd_top.sv]
// Windowed watchdog timer with protected configuration and debug halt handling.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - A non-zero period selection enables the watchdog; zero keeps it off.
// - A non-zero window selection adds a closed window before the open one.
// - Control A and lock writes only succeed after the protection unlock.
// - Control A takes its value from the boot fuse after reset.
// - Lock bit is set at boot when the fuse enables the watchdog.
// - No restart before the timeout elapses raises a system reset.
// - Each restart in the open window clears the counter and starts a fresh period.
// - Eleven timeout lengths from 8 ms up to 8 s.
// - Counting stops while the debugger halts the core.
// - A debug halt clears the counter to zero.
// - After a halt in window mode one normal timeout replaces the closed window.
module wwd_top #(
  parameter int unsigned TICK_CYCLES = wwd_pkg::TICK_CYC,
  parameter int unsigned CCP_CYCLES = wwd_pkg::CCP_OPEN_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [wwd_pkg::CTRL_W-1:0] boot_watchdog_config_fuse,
  input wire logic config_change_protect,
  input wire logic ctrl_wr_en,
  input wire logic [wwd_pkg::CTRL_W-1:0] ctrl_wr_data,
  input wire logic lock_wr_en,
  input wire logic lock_wr_data,
  input wire logic watchdog_restart_instr,
  input wire logic core_halted,
  output logic [wwd_pkg::CTRL_W-1:0] control_a,
  output logic status_lock,
  output logic ccp_open,
  output logic wd_active,
  output logic wd_window_closed,
  output logic system_reset
);
  localparam int unsigned CCW = $clog2(CCP_CYCLES + 1);
  localparam logic [CCW-1:0] CCP_LOAD = CCW'(CCP_CYCLES);
  localparam logic [CCW-1:0] CCP_ZERO = '0;
  localparam logic [CCW-1:0] CCP_ONE = CCW'(1);
  localparam logic [wwd_pkg::MS_W-1:0] MS_ZERO = '0;
  localparam logic [wwd_pkg::MS_W-1:0] MS_ONE = wwd_pkg::MS_W'(1);

  // ===========================================================================
  // Timeout decode
  // Codes above the last step are reserved; they clamp to the longest period.
  function automatic logic [wwd_pkg::MS_W-1:0] sel_to_ms(input logic [wwd_pkg::SEL_W-1:0] sel);
    logic [wwd_pkg::SEL_W-1:0] s;
    s = (sel > wwd_pkg::SEL_MAX) ? wwd_pkg::SEL_MAX : sel;
    if (s == wwd_pkg::SEL_OFF) begin
      sel_to_ms = MS_ZERO;
    end else begin
      sel_to_ms = wwd_pkg::BASE_MS << (s - wwd_pkg::SEL_ONE);
    end
  endfunction

  function automatic logic [wwd_pkg::SEL_W-1:0] period_of(input logic [wwd_pkg::CTRL_W-1:0] c);
    period_of = c[wwd_pkg::PERIOD_LSB +: wwd_pkg::SEL_W];
  endfunction

  function automatic logic [wwd_pkg::SEL_W-1:0] window_of(input logic [wwd_pkg::CTRL_W-1:0] c);
    window_of = c[wwd_pkg::WINDOW_LSB +: wwd_pkg::SEL_W];
  endfunction

  // ===========================================================================
  // Reset release
  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  assign rst_n = rst_sync2_reg;

  // ===========================================================================
  // Configuration change protection
  logic [CCW-1:0] ccp_cnt_reg;
  logic ccp_open_reg;
  logic unlocked;

  assign unlocked = (ccp_cnt_reg != CCP_ZERO);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ccp_cnt_reg <= CCP_ZERO;
      ccp_open_reg <= 1'b0;
    end else if (config_change_protect) begin
      ccp_cnt_reg <= CCP_LOAD;
      ccp_open_reg <= 1'b1;
    end else if (unlocked) begin
      ccp_cnt_reg <= ccp_cnt_reg - CCP_ONE;
      ccp_open_reg <= (ccp_cnt_reg != CCP_ONE);
    end
  end

  // ===========================================================================
  // Control A and lock
  logic [wwd_pkg::CTRL_W-1:0] control_a_reg;
  logic lock_reg;
  logic boot_done_reg;

  // fuse load after release
  // The fuse is caught by a clocked load, since a reset value may not be a port.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      control_a_reg <= wwd_pkg::CTRL_RESET;
      boot_done_reg <= 1'b0;
    end else if (!boot_done_reg) begin
      control_a_reg <= boot_watchdog_config_fuse;
      boot_done_reg <= 1'b1;
    end else if (ctrl_wr_en && unlocked && !lock_reg) begin
      control_a_reg <= ctrl_wr_data;
    end
  end

  // boot lock from fuse
  // Once set, the lock only falls with a reset, so a locked setup cannot be undone.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lock_reg <= 1'b0;
    end else if (!boot_done_reg) begin
      lock_reg <= (period_of(boot_watchdog_config_fuse) != wwd_pkg::SEL_OFF);
    end else if (lock_wr_en && lock_wr_data && unlocked) begin
      lock_reg <= 1'b1;
    end
  end

  // ===========================================================================
  // Timeout sequencer
  logic [wwd_pkg::SEL_W-1:0] period_sel;
  logic [wwd_pkg::SEL_W-1:0] window_sel;
  logic [wwd_pkg::MS_W-1:0] period_ms;
  logic [wwd_pkg::MS_W-1:0] window_ms;
  logic enabled;
  logic tick;
  logic tick_clear;
  wwd_pkg::wwd_state_t state_reg;
  wwd_pkg::wwd_state_t state_next;
  logic [wwd_pkg::MS_W-1:0] ms_reg;
  logic [wwd_pkg::MS_W-1:0] ms_next;
  logic fire;
  logic system_reset_reg;
  logic active_reg;
  logic closed_reg;

  assign period_sel = period_of(control_a_reg);
  assign window_sel = window_of(control_a_reg);
  assign period_ms = sel_to_ms(period_sel);
  assign window_ms = sel_to_ms(window_sel);
  assign enabled = boot_done_reg && (period_sel != wwd_pkg::SEL_OFF);

  always_comb begin
    state_next = state_reg;
    ms_next = ms_reg;
    fire = 1'b0;
    tick_clear = 1'b0;
    if (!enabled) begin
      state_next = wwd_pkg::WWD_OFF;
      ms_next = MS_ZERO;
      tick_clear = 1'b1;
    end else if (core_halted) begin
      state_next = wwd_pkg::WWD_OPEN;
      ms_next = MS_ZERO;
      tick_clear = 1'b1;
    end else begin
      case (state_reg)
        wwd_pkg::WWD_OFF: begin
          state_next = (window_sel != wwd_pkg::SEL_OFF) ? wwd_pkg::WWD_CLOSED : wwd_pkg::WWD_OPEN;
          ms_next = MS_ZERO;
          tick_clear = 1'b1;
        end
        wwd_pkg::WWD_CLOSED: begin
          if (watchdog_restart_instr) begin
            fire = 1'b1;
          end else if (window_sel == wwd_pkg::SEL_OFF) begin
            state_next = wwd_pkg::WWD_OPEN;
            ms_next = MS_ZERO;
            tick_clear = 1'b1;
          end else if (tick && (ms_reg + MS_ONE >= window_ms)) begin
            state_next = wwd_pkg::WWD_OPEN;
            ms_next = MS_ZERO;
          end else if (tick) begin
            ms_next = ms_reg + MS_ONE;
          end
        end
        wwd_pkg::WWD_OPEN: begin
          if (watchdog_restart_instr) begin
            state_next = (window_sel != wwd_pkg::SEL_OFF) ? wwd_pkg::WWD_CLOSED : wwd_pkg::WWD_OPEN;
            ms_next = MS_ZERO;
            tick_clear = 1'b1;
          end else if (tick && (ms_reg + MS_ONE >= period_ms)) begin
            fire = 1'b1;
          end else if (tick) begin
            ms_next = ms_reg + MS_ONE;
          end
        end
        default: begin
          state_next = wwd_pkg::WWD_OFF;
          ms_next = MS_ZERO;
        end
      endcase
    end
  end

  wwd_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clear(tick_clear),
    .tick(tick)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= wwd_pkg::WWD_OFF;
      ms_reg <= MS_ZERO;
      active_reg <= 1'b0;
      closed_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ms_reg <= ms_next;
      active_reg <= (state_next != wwd_pkg::WWD_OFF);
      closed_reg <= (state_next == wwd_pkg::WWD_CLOSED);
    end
  end

  // reset request held
  // The request stays high until the system reset comes back through rst_b.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      system_reset_reg <= 1'b0;
    end else if (fire) begin
      system_reset_reg <= 1'b1;
    end
  end

  // ===========================================================================
  // Outputs
  assign control_a = control_a_reg;
  assign status_lock = lock_reg;
  assign ccp_open = ccp_open_reg;
  assign wd_active = active_reg;
  assign wd_window_closed = closed_reg;
  assign system_reset = system_reset_reg;
endmodule
`default_nettype wire

// [tb/wwd_props.sv]
// Port checker of the windowed watchdog.
`timescale 1ns/1ps
`default_nettype none
module wwd_props #(
  parameter int unsigned TICK_CYCLES = 4,
  parameter int unsigned CCP_CYCLES = 4
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [wwd_pkg::CTRL_W-1:0] boot_watchdog_config_fuse,
  input wire logic config_change_protect,
  input wire logic ctrl_wr_en,
  input wire logic [wwd_pkg::CTRL_W-1:0] ctrl_wr_data,
  input wire logic lock_wr_en,
  input wire logic lock_wr_data,
  input wire logic watchdog_restart_instr,
  input wire logic core_halted,
  input wire logic [wwd_pkg::CTRL_W-1:0] control_a,
  input wire logic status_lock,
  input wire logic ccp_open,
  input wire logic wd_active,
  input wire logic wd_window_closed,
  input wire logic system_reset
);
  logic [wwd_pkg::SEL_W-1:0] period_field;

  assign period_field = control_a[wwd_pkg::PERIOD_LSB +: wwd_pkg::SEL_W];

  // ===========================================================================
  // Sequences and properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_unlock;
    config_change_protect;
  endsequence
  sequence s_kick_closed;
    watchdog_restart_instr && wd_window_closed && !core_halted;
  endsequence
  sequence s_halt2;
    core_halted [*2];
  endsequence
  // The open span below assumes the bench runs the unlock window at four cycles.
  chk_unlock_window: assert property (s_unlock |=> ccp_open [*4])
    else $error("unlock window closed early");
  chk_write_taken: assert property (ctrl_wr_en && ccp_open && !status_lock |=> control_a == $past(ctrl_wr_data))
    else $error("accepted write lost");
  chk_write_refused: assert property (ctrl_wr_en && (!ccp_open || status_lock) |=> $stable(control_a))
    else $error("refused write applied");
  chk_lock_taken: assert property (lock_wr_en && lock_wr_data && ccp_open |=> status_lock)
    else $error("lock write lost");
  chk_lock_sticky: assert property (status_lock |=> status_lock)
    else $error("lock bit cleared");
  chk_enable_start: assert property (period_field != wwd_pkg::SEL_OFF && !wd_active && !system_reset |=> wd_active)
    else $error("watchdog did not start");
  chk_off_stays: assert property (period_field == wwd_pkg::SEL_OFF && !wd_active |=> !wd_active)
    else $error("watchdog started while off");
  chk_closed_kick: assert property (s_kick_closed |=> system_reset)
    else $error("closed window restart missed");
  chk_halt_open: assert property (core_halted && wd_active |=> !wd_window_closed)
    else $error("closed window during halt");
  chk_halt_quiet: assert property (s_halt2 |=> !$rose(system_reset))
    else $error("reset while halted");
  chk_reset_sticky: assert property (system_reset |=> system_reset)
    else $error("reset request dropped");
endmodule
bind wwd_top wwd_props #(.TICK_CYCLES(TICK_CYCLES), .CCP_CYCLES(CCP_CYCLES)) props_u (
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .boot_watchdog_config_fuse(boot_watchdog_config_fuse),
  .config_change_protect(config_change_protect),
  .ctrl_wr_en(ctrl_wr_en),
  .ctrl_wr_data(ctrl_wr_data),
  .lock_wr_en(lock_wr_en),
  .lock_wr_data(lock_wr_data),
  .watchdog_restart_instr(watchdog_restart_instr),
  .core_halted(core_halted),
  .control_a(control_a),
  .status_lock(status_lock),
  .ccp_open(ccp_open),
  .wd_active(wd_active),
  .wd_window_closed(wd_window_closed),
  .system_reset(system_reset)
);
`default_nettype wire

// [tb/wwd_core_model.sv]
// Processor core model that retires restart instructions after a lag.
`timescale 1ns/1ps
`default_nettype none
module wwd_core_model (
  input wire logic clk_sys,
  input wire logic kick_req,
  input wire logic [2:0] lag,
  output logic watchdog_restart_instr
);
  logic [7:0] pipe_reg;
  // A slow core retires the restart some cycles after it is fetched.
  always_ff @(posedge clk_sys) begin
    pipe_reg <= {pipe_reg[6:0], kick_req};
  end
  assign watchdog_restart_instr = pipe_reg[lag];
endmodule
`default_nettype wire

// [tb/windowed_watchdog_timer_tb_top.sv]
// Self-checking bench of the windowed watchdog.
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_timer_tb_top;
  localparam int T = 4;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [wwd_pkg::CTRL_W-1:0] boot_watchdog_config_fuse = 8'h00;
  logic config_change_protect = 1'b0;
  logic ctrl_wr_en = 1'b0;
  logic [wwd_pkg::CTRL_W-1:0] ctrl_wr_data = 8'h00;
  logic lock_wr_en = 1'b0;
  logic lock_wr_data = 1'b0;
  logic kick_req = 1'b0;
  logic [2:0] lag = 3'h0;
  logic core_halted = 1'b0;
  logic watchdog_restart_instr;
  logic [wwd_pkg::CTRL_W-1:0] control_a;
  logic status_lock, ccp_open, wd_active, wd_window_closed, system_reset;
  int n_fail = 0;
  int samples_checked = 0;
  int n;
  always #12.5 clk_sys = ~clk_sys;
  wwd_top #(.TICK_CYCLES(T), .CCP_CYCLES(4)) dut_u (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .boot_watchdog_config_fuse(boot_watchdog_config_fuse),
    .config_change_protect(config_change_protect),
    .ctrl_wr_en(ctrl_wr_en),
    .ctrl_wr_data(ctrl_wr_data),
    .lock_wr_en(lock_wr_en),
    .lock_wr_data(lock_wr_data),
    .watchdog_restart_instr(watchdog_restart_instr),
    .core_halted(core_halted),
    .control_a(control_a),
    .status_lock(status_lock),
    .ccp_open(ccp_open),
    .wd_active(wd_active),
    .wd_window_closed(wd_window_closed),
    .system_reset(system_reset)
  );
  wwd_core_model core_u (
    .clk_sys(clk_sys),
    .kick_req(kick_req),
    .lag(lag),
    .watchdog_restart_instr(watchdog_restart_instr)
  );
  // ===========================================================================
  // Access tasks
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic boot(input logic [7:0] f);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    boot_watchdog_config_fuse <= f;
    cyc(6);
    rst_b <= 1'b1;
    cyc(5);
    #1;
  endtask
  // Writes control A, or sets the lock when lk is high.
  task automatic wr(input logic [7:0] d, input logic unlock, input logic lk);
    @(posedge clk_sys);
    config_change_protect <= unlock;
    @(posedge clk_sys);
    config_change_protect <= 1'b0;
    ctrl_wr_en <= ~lk;
    lock_wr_en <= lk;
    lock_wr_data <= lk;
    ctrl_wr_data <= d;
    @(posedge clk_sys);
    ctrl_wr_en <= 1'b0;
    lock_wr_en <= 1'b0;
    cyc(1);
    #1;
  endtask
  task automatic kick();
    @(posedge clk_sys);
    kick_req <= 1'b1;
    @(posedge clk_sys);
    kick_req <= 1'b0;
  endtask
  // Bounded wait on system_reset, or on wd_window_closed when pick_closed is high; n returns the cycles spent.
  task automatic wait_for(input logic pick_closed, input logic lvl, input int lim);
    n = 0;
    while ((pick_closed ? wd_window_closed : system_reset) !== lvl && n < lim) begin
      cyc(1);
      #1;
      n++;
    end
  endtask
  // ===========================================================================
  // Tests
  initial begin
    int ms;
    boot(8'h00);
    chk("control_a", control_a, 8'h00);
    chk("wd_active", {7'h00, wd_active}, 8'h00);
    wr(8'h03, 1'b0, 1'b0);
    chk("control_a", control_a, 8'h00);
    for (int s = 1; s <= 3; s++) begin
      ms = 8 << (s - 1);
      boot(8'h00);
      wr(s[7:0], 1'b1, 1'b0);
      chk("wd_active", {7'h00, wd_active}, 8'h01);
      lag <= s[2:0];
      repeat (3) begin
        cyc(ms * T - 10);
        kick();
      end
      wait_for(1'b0, 1'b1, ms * T + 12);
      chk("timeout span", 8'(n >= ms * T && n <= ms * T + 8), 8'h01);
    end
    lag <= 3'h0;
    boot(8'h00);
    wr(8'h11, 1'b1, 1'b0);
    chk("wd_window_closed", {7'h00, wd_window_closed}, 8'h01);
    wait_for(1'b1, 1'b0, 8 * T + 8);
    chk("closed span", 8'(n >= 8 * T - 4 && n <= 8 * T + 4), 8'h01);
    kick();
    cyc(4);
    #1;
    chk("system_reset", {7'h00, system_reset}, 8'h00);
    chk("wd_window_closed", {7'h00, wd_window_closed}, 8'h01);
    kick();
    cyc(3);
    #1;
    chk("system_reset", {7'h00, system_reset}, 8'h01);
    boot(8'h00);
    wr(8'h00, 1'b1, 1'b1);
    chk("ccp_open", {7'h00, ccp_open}, 8'h01);
    cyc(2);
    #1;
    chk("ccp_open", {7'h00, ccp_open}, 8'h00);
    wr(8'h02, 1'b1, 1'b0);
    chk("status_lock", {7'h00, status_lock}, 8'h01);
    chk("control_a", control_a, 8'h00);
    boot(8'h11);
    chk("control_a", control_a, 8'h11);
    chk("status_lock", {7'h00, status_lock}, 8'h01);
    wr(8'h00, 1'b1, 1'b0);
    chk("control_a", control_a, 8'h11);
    @(posedge clk_sys);
    core_halted <= 1'b1;
    cyc(100);
    core_halted <= 1'b0;
    cyc(2);
    #1;
    chk("system_reset", {7'h00, system_reset}, 8'h00);
    chk("wd_window_closed", {7'h00, wd_window_closed}, 8'h00);
    wait_for(1'b0, 1'b1, 8 * T + 12);
    chk("resume span", 8'(n >= 8 * T - 2 && n <= 8 * T + 4), 8'h01);
    finish_test();
  end
  // Well above the twelve hundred or so cycles the tests need.
  initial begin
    #(20000 * 25);
    n_fail++;
    finish_test();
  end
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
endmodule
`default_nettype wire
